// file: verilog/svih_pkg.sv
// Constants, register map and state type of the single-vector interrupt handler.
package svih_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_EXT     = 8;
	localparam int NUM_SRC     = 16;
	localparam int NUM_ID      = 9;
	localparam int ADDR_W      = 16;
	localparam int STACK_DEPTH = 16;
	localparam int STACK_IDX_W = 4;
	localparam int FILTER_LEN  = 3;
	localparam int SYS_SRC     = 15;
	localparam int SYS_ID_BIT  = 8;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MASK    = 8'h04;
	localparam logic [7:0] OFS_VECTOR  = 8'h08;
	localparam logic [7:0] OFS_ID      = 8'h0C;
	localparam logic [7:0] OFS_FLAGS   = 8'h10;
	localparam logic [7:0] OFS_LOCAL   = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTL_GIE_BIT = 0;
	localparam int CTL_INS_BIT = 1;
	localparam logic [ADDR_W-1:0]      RST_VECTOR    = 16'h0000;
	localparam logic [NUM_ID-1:0]      RST_MASK      = 9'h000;
	localparam logic [NUM_SRC-1:0]     RST_LOCAL     = 16'h0000;
	localparam logic [STACK_IDX_W-1:0] RST_STACK_IDX = 4'hF;

	typedef enum logic [1:0] {
		SVIH_IDLE,
		SVIH_STALL,
		SVIH_VECTOR,
		SVIH_RETURN
	} svih_state_type;
endpackage

// file: verilog/svih_stack_if.sv
// Connection between the handler sequencer and its return-address stack.
`timescale 1ns/10ps
`default_nettype none
interface svih_stack_if;
	logic                               push;
	logic                               pop;
	logic [svih_pkg::ADDR_W-1:0]        push_data;
	logic [svih_pkg::ADDR_W-1:0]        pop_data;
	logic [svih_pkg::STACK_IDX_W-1:0]   index;

	modport owner (output push, output pop, output push_data, input pop_data, input index);
	modport store (input push, input pop, input push_data, output pop_data, output index);
endinterface
`default_nettype wire

// file: verilog/svih_filter.sv
// Two-stage synchroniser and three-sample glitch filter for external requests.
`timescale 1ns/10ps
`default_nettype none
module svih_filter
(
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	input  wire logic [svih_pkg::NUM_EXT-1:0]  pin_in,
	output logic      [svih_pkg::NUM_EXT-1:0]  rise_out
);
	genvar g;
	generate
		for (g = 0; g < svih_pkg::NUM_EXT; g++)
		begin : gen_ch
			logic [1:0]                       sync_ff;
			logic [svih_pkg::FILTER_LEN-1:0]  hist_ff;
			logic                             level_ff;
			logic [1:0]                       nxt_sync;
			logic [svih_pkg::FILTER_LEN-1:0]  nxt_hist;
			logic                             nxt_level;

			// Only the second stage feeds the history, so metastability stays contained.
			always_comb
			begin
				nxt_sync  = {sync_ff[0], pin_in[g]};
				nxt_hist  = {hist_ff[svih_pkg::FILTER_LEN-2:0], sync_ff[1]};
				nxt_level = (&hist_ff) ? 1'b1 : ((|hist_ff) ? level_ff : 1'b0);
			end

			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					sync_ff  <= 2'h0;
					hist_ff  <= '0;
					level_ff <= 1'b0;
				end
				else
				begin
					sync_ff  <= nxt_sync;
					hist_ff  <= nxt_hist;
					level_ff <= nxt_level;
				end
			end

			assign rise_out[g] = (&hist_ff) & ~level_ff;
		end
	endgenerate
endmodule
`default_nettype wire

// file: verilog/svih_stack.sv
// Return-address stack: sixteen words, index points at the top entry.
`timescale 1ns/10ps
`default_nettype none
module svih_stack
(
	input  wire logic  clock,
	input  wire logic  rst_n,
	svih_stack_if.store stk
);
	logic [svih_pkg::ADDR_W-1:0]      mem [svih_pkg::STACK_DEPTH];
	logic [svih_pkg::STACK_IDX_W-1:0] index_ff;
	logic [svih_pkg::STACK_IDX_W-1:0] nxt_index;

	always_comb
	begin
		nxt_index = index_ff;
		if (stk.push)
			nxt_index = index_ff + 4'h1;
		else if (stk.pop)
			nxt_index = index_ff - 4'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			index_ff <= svih_pkg::RST_STACK_IDX;
		else
			index_ff <= nxt_index;
	end

	// Stack memory is not reset; contents are undefined until pushed.
	always_ff @(posedge clock)
	begin
		if (stk.push)
			mem[nxt_index] <= stk.push_data;
	end

	assign stk.pop_data = mem[index_ff];
	assign stk.index    = index_ff;
endmodule
`default_nettype wire

// file: verilog/svih_top.sv
// Single-vector interrupt handler with Wishbone register access.
`timescale 1ns/10ps
`default_nettype none
module svih_top
(
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	input  wire logic [svih_pkg::NUM_EXT-1:0] ext_irq,
	input  wire logic [7:0]                   int_event,
	input  wire logic                         core_return_from_handler,
	input  wire logic                         core_pfx_wr,
	input  wire logic [15:0]                  core_ret_addr,
	output logic                              cpu_fetch_cancel,
	output logic                              cpu_pc_load,
	output logic      [15:0]                  cpu_pc_value,
	output logic                              irq_in_service
);
	// ************************************************************
	// Source conditioning
	// ************************************************************
	logic [svih_pkg::NUM_EXT-1:0] ext_rise;
	logic [svih_pkg::NUM_SRC-1:0] src_event;

	svih_filter u_filter
	(
		.clock    (clock),
		.rst_n    (rst_n),
		.pin_in   (ext_irq),
		.rise_out (ext_rise)
	);

	// External pins fill the low byte; internal events arrive already synchronous.
	assign src_event = {int_event, ext_rise};

	svih_stack_if stk ();

	svih_stack u_stack
	(
		.clock (clock),
		.rst_n (rst_n),
		.stk   (stk)
	);

	// ************************************************************
	// Register state
	// ************************************************************
	logic                           gie_ff;
	logic                           ins_ff;
	logic [svih_pkg::NUM_ID-1:0]    mask_ff;
	logic [15:0]                    vector_ff;
	logic [svih_pkg::NUM_SRC-1:0]   flag_ff;
	logic [svih_pkg::NUM_SRC-1:0]   local_ff;
	logic                           ack_ff;
	logic [31:0]                    rdata_ff;
	logic                           nxt_gie;
	logic                           nxt_ins;
	logic [svih_pkg::NUM_ID-1:0]    nxt_mask;
	logic [15:0]                    nxt_vector;
	logic [svih_pkg::NUM_SRC-1:0]   nxt_flag;
	logic [svih_pkg::NUM_SRC-1:0]   nxt_local;
	logic                           nxt_ack;
	logic [31:0]                    nxt_rdata;

	// ************************************************************
	// Sequencer state
	// ************************************************************
	svih_pkg::svih_state_type       state_ff;
	svih_pkg::svih_state_type       nxt_state;
	logic                           req_ff;
	logic                           window_ff;
	logic [15:0]                    pc_ff;
	logic                           nxt_req;
	logic                           nxt_window;
	logic [15:0]                    nxt_pc;

	logic [svih_pkg::NUM_SRC-1:0]   src_active;
	logic [svih_pkg::NUM_ID-1:0]    module_id;
	logic                           pending;
	logic                           enter;
	logic                           wr_stb;
	logic [15:0]                    wmask;
	logic [15:0]                    wdata;

	// ************************************************************
	// Identification and qualification
	// ************************************************************
	assign src_active = flag_ff & local_ff;

	// External sources share module 0; internal events map to modules 1..7, last is system.
	assign module_id[0] = |src_active[svih_pkg::NUM_EXT-1:0];
	genvar m;
	generate
		for (m = 1; m < svih_pkg::SYS_ID_BIT; m++)
		begin : gen_mod
			assign module_id[m] = src_active[m + svih_pkg::NUM_EXT - 1];
		end
	endgenerate
	assign module_id[svih_pkg::SYS_ID_BIT] = src_active[svih_pkg::SYS_SRC];

	// All sources OR into one request, so none is ranked above another.
	// Only the request is gated; the ID read still shows modules that are masked.
	assign pending = (|(module_id & mask_ff)) & gie_ff & ~ins_ff;

	// ************************************************************
	// Wishbone slave: ack one cycle after the strobe, write at the acked edge
	// ************************************************************
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
	assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata  = wb_dat_i[15:0] & wmask;
	assign enter  = (state_ff == svih_pkg::SVIH_VECTOR);

	// Read data is captured on the request edge, so it stands while ack is high and holds until the next request.
	always_comb
	begin
		nxt_ack    = wb_cyc_i & wb_stb_i & ~ack_ff;
		nxt_rdata  = rdata_ff;
		nxt_gie    = gie_ff;
		nxt_ins    = ins_ff;
		nxt_mask   = mask_ff;
		nxt_vector = vector_ff;
		nxt_local  = local_ff;
		nxt_flag   = flag_ff;
		if (wb_cyc_i & wb_stb_i & ~ack_ff)
		begin
			unique case (wb_adr_i)
				svih_pkg::OFS_CONTROL : nxt_rdata = {30'h0, ins_ff, gie_ff};
				svih_pkg::OFS_MASK    : nxt_rdata = {23'h0, mask_ff};
				svih_pkg::OFS_VECTOR  : nxt_rdata = {16'h0, vector_ff};
				svih_pkg::OFS_ID      : nxt_rdata = {23'h0, module_id};
				svih_pkg::OFS_FLAGS   : nxt_rdata = {16'h0, flag_ff};
				svih_pkg::OFS_LOCAL   : nxt_rdata = {16'h0, local_ff};
				svih_pkg::OFS_STATUS  : nxt_rdata = {24'h0, 2'h0, state_ff, stk.index};
				default               : nxt_rdata = 32'h0000_0000;
			endcase
		end
		// A write lands at the edge where ack is high, the edge at which the master samples it.
		if (wr_stb)
		begin
			unique case (wb_adr_i)
				svih_pkg::OFS_CONTROL :
				begin
					if (wb_sel_i[0])
					begin
						nxt_gie = wb_dat_i[svih_pkg::CTL_GIE_BIT];
						nxt_ins = wb_dat_i[svih_pkg::CTL_INS_BIT];
					end
				end
				svih_pkg::OFS_MASK    : nxt_mask = (mask_ff & ~wmask[svih_pkg::NUM_ID-1:0])
				                                   | wdata[svih_pkg::NUM_ID-1:0];
				svih_pkg::OFS_VECTOR  : nxt_vector = (vector_ff & ~wmask) | wdata;
				svih_pkg::OFS_FLAGS   : nxt_flag = flag_ff & ~wdata;
				svih_pkg::OFS_LOCAL   : nxt_local = (local_ff & ~wmask) | wdata;
				default               : nxt_rdata = rdata_ff;
			endcase
		end
		// Hardware wins over a software clear in the same cycle.
		nxt_flag = nxt_flag | src_event;
		if (core_return_from_handler && state_ff == svih_pkg::SVIH_IDLE)
			nxt_ins = 1'b0;
		if (enter)
			nxt_ins = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_ff    <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			gie_ff    <= 1'b0;
			ins_ff    <= 1'b0;
			mask_ff   <= svih_pkg::RST_MASK;
			vector_ff <= svih_pkg::RST_VECTOR;
			local_ff  <= svih_pkg::RST_LOCAL;
			flag_ff   <= '0;
		end
		else
		begin
			ack_ff    <= nxt_ack;
			rdata_ff  <= nxt_rdata;
			gie_ff    <= nxt_gie;
			ins_ff    <= nxt_ins;
			mask_ff   <= nxt_mask;
			vector_ff <= nxt_vector;
			local_ff  <= nxt_local;
			flag_ff   <= nxt_flag;
		end
	end

	// ************************************************************
	// Call and return sequencer
	// ************************************************************
	// In SVIH_IDLE a request is taken from req_ff, the value sampled one edge earlier.
	always_comb
	begin
		nxt_req    = pending;
		nxt_window = core_pfx_wr;
		nxt_state  = state_ff;
		nxt_pc     = pc_ff;
		unique case (state_ff)
			svih_pkg::SVIH_IDLE :
			begin
				if (core_return_from_handler)
				begin
					nxt_pc    = stk.pop_data;
					nxt_state = svih_pkg::SVIH_RETURN;
				end
				// The in-service test covers the cycle after a call, while req_ff holds an older sample.
				else if (req_ff && !window_ff && !ins_ff)
					nxt_state = svih_pkg::SVIH_STALL;
			end
			svih_pkg::SVIH_STALL :
			begin
				// A prefix written by the stalled instruction opens a window in the next cycle,
				// so the call waits until that cycle has passed.
				if (!core_pfx_wr)
				begin
					nxt_pc    = vector_ff;
					nxt_state = svih_pkg::SVIH_VECTOR;
				end
			end
			svih_pkg::SVIH_VECTOR :
				nxt_state = svih_pkg::SVIH_IDLE;
			svih_pkg::SVIH_RETURN :
			begin
				// Acknowledge here, after the return, never during it.
				// The live request is used because req_ff was sampled while in-service was still set.
				if (pending && !window_ff)
					nxt_state = svih_pkg::SVIH_STALL;
				else
					nxt_state = svih_pkg::SVIH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff  <= svih_pkg::SVIH_IDLE;
			req_ff    <= 1'b0;
			window_ff <= 1'b0;
			pc_ff     <= 16'h0000;
		end
		else
		begin
			state_ff  <= nxt_state;
			req_ff    <= nxt_req;
			window_ff <= nxt_window;
			pc_ff     <= nxt_pc;
		end
	end

	// ************************************************************
	// Stack and core outputs
	// ************************************************************
	// The stack index wraps silently on overflow; software must keep nesting at or below sixteen.
	assign stk.push      = enter;
	assign stk.push_data = core_ret_addr;
	assign stk.pop       = core_return_from_handler & (state_ff == svih_pkg::SVIH_IDLE);

	// Core strobes decode registered state, so each stands for exactly one cycle.
	assign cpu_fetch_cancel = enter;
	assign cpu_pc_load      = enter | (state_ff == svih_pkg::SVIH_RETURN);
	assign cpu_pc_value     = pc_ff;
	assign irq_in_service   = ins_ff;
	assign wb_ack_o         = ack_ff;
	assign wb_dat_o         = rdata_ff;
endmodule
`default_nettype wire

// file: test/svih_top_assertions.sv
// Concurrent checks on the top-level ports of the interrupt handler.
`timescale 1ns/10ps
`default_nettype none
module svih_top_assertions
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        core_return_from_handler,
	input wire logic        core_pfx_wr,
	input wire logic        cpu_fetch_cancel,
	input wire logic        cpu_pc_load,
	input wire logic [15:0] cpu_pc_value,
	input wire logic        irq_in_service
);
	// ************************************************************
	// Shadow of vector and global enable
	// ************************************************************
	// Only full low-half writes are tracked; the bench never writes partial words.
	logic [15:0] vec_ff;
	logic [15:0] nxt_vec;
	logic        gie_ff;
	logic        nxt_gie;
	logic        wr;
	always_comb
	begin
		wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_sel_i[1:0] == 2'h3);
		nxt_vec = (wr && wb_adr_i == svih_pkg::OFS_VECTOR) ? wb_dat_i[15:0] : vec_ff;
		nxt_gie = (wr && wb_adr_i == svih_pkg::OFS_CONTROL) ? wb_dat_i[svih_pkg::CTL_GIE_BIT] : gie_ff;
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vec_ff <= svih_pkg::RST_VECTOR;
			gie_ff <= 1'b0;
		end
		else
		begin
			vec_ff <= nxt_vec;
			gie_ff <= nxt_gie;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_vec_addr; cpu_fetch_cancel |-> cpu_pc_value == vec_ff; endproperty
	a_vec_addr: assert property (p_vec_addr)
		else $error("jump address differs from vector register");
	property p_gie_off; !gie_ff [*4] |-> !cpu_fetch_cancel; endproperty
	a_gie_off: assert property (p_gie_off)
		else $error("call taken with global enable low");
	property p_call_seq; cpu_fetch_cancel |-> cpu_pc_load && !irq_in_service ##1 irq_in_service; endproperty
	a_call_seq: assert property (p_call_seq)
		else $error("call sequence incomplete");
	property p_no_reentry; irq_in_service |-> !cpu_fetch_cancel; endproperty
	a_no_reentry: assert property (p_no_reentry)
		else $error("call while in service");
	property p_spacing; cpu_fetch_cancel |=> !cpu_fetch_cancel [*2]; endproperty
	a_spacing: assert property (p_spacing)
		else $error("calls too close together");
	property p_ret; core_return_from_handler && irq_in_service && !cpu_fetch_cancel
		|=> cpu_pc_load && !cpu_fetch_cancel && !irq_in_service ##1 !cpu_fetch_cancel; endproperty
	a_ret: assert property (p_ret)
		else $error("return sequence wrong");
	property p_load_cause; cpu_pc_load && !cpu_fetch_cancel |-> $past(core_return_from_handler); endproperty
	a_load_cause: assert property (p_load_cause)
		else $error("pointer load without return");
	property p_window; core_pfx_wr |=> !cpu_fetch_cancel; endproperty
	a_window: assert property (p_window)
		else $error("call inside exception window");
endmodule
`default_nettype wire

// file: test/svih_core_model.sv
// Behavioural processor core that follows pointer loads and issues returns.
`timescale 1ns/10ps
`default_nettype none
module svih_core_model
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        want_return_from_handler,
	input wire logic        cpu_fetch_cancel,
	input wire logic        cpu_pc_load,
	input wire logic [15:0] cpu_pc_value,
	output logic            core_return_from_handler,
	output logic     [15:0] core_ret_addr
);
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_return_from_handler     <= 1'b0;
			core_ret_addr <= 16'h0100;
		end
		else
		begin
			core_ret_addr <= cpu_pc_load ? cpu_pc_value : core_ret_addr + 16'h0001;
			// A routine ends with one return; none is issued in the cycle after a call.
			core_return_from_handler <= want_return_from_handler && !core_return_from_handler && !cpu_fetch_cancel;
		end
	end
endmodule
`default_nettype wire

// file: test/test_svih_top.sv
// Self-checking bench for the single-vector interrupt handler.
`timescale 1ns/10ps
`default_nettype none
module test_svih_top;
	logic clock, rst_n, cyc, stb, we, want, prefix_hold_reg, ack, cancel, load, in_service_flag, return_from_handler;
	logic [7:0]  adr, ev, ext;
	logic [3:0]  sel;
	logic [31:0] dat, rd, dat_o, seed;
	logic [15:0] pcv, ra, v, rexp, rout;
	logic [2:0]  k, b;
	int          num_errors, cmp_count, n, i;
	logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1C};
	logic [31:0] rstv[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hF, 32'h0};
	svih_top DUT (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ext_irq(ext), .int_event(ev), .core_return_from_handler(return_from_handler), .core_pfx_wr(prefix_hold_reg), .core_ret_addr(ra),
		.cpu_fetch_cancel(cancel), .cpu_pc_load(load), .cpu_pc_value(pcv), .irq_in_service(in_service_flag));
	svih_core_model core (.clock(clock), .rst_n(rst_n), .want_return_from_handler(want), .cpu_fetch_cancel(cancel),
		.cpu_pc_load(load), .cpu_pc_value(pcv), .core_return_from_handler(return_from_handler), .core_ret_addr(ra));
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] idb(input logic [2:0] m);
		return (m == 3'h7) ? 32'h100 : 32'h2 << m;
	endfunction
	task conclude;
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clock);
		end
		while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("register read", rd, e);
	endtask
	// Counts edges until a call shows; the prefix write lands in the stall cycle.
	task automatic wcan(input logic p, output int c);
		c = 0;
		do
		begin
			@(posedge clock);
			ev <= 8'h00;
			prefix_hold_reg <= p && c == 2;
			c++;
			#1;
		end
		while (cancel !== 1'b1 && c < 12);
	endtask
	task automatic fire(input logic [7:0] m, input logic p, output int c);
		@(posedge clock);
		ev <= m;
		wcan(p, c);
	endtask
	task automatic ret;
		@(posedge clock);
		want <= 1'b1;
		do
		begin
			@(posedge clock);
			#1;
		end
		while (return_from_handler !== 1'b1);
		@(posedge clock);
		want <= 1'b0;
		#1;
		chk("return load", 32'({load, in_service_flag, pcv}), 32'({2'b10, rexp}));
	endtask
	// ************************************************************
	// Sequence
	// ************************************************************
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		num_errors++;
		conclude();
	end
	initial
	begin
		{rst_n, cyc, stb, we, want, prefix_hold_reg, adr, ev, ext, dat} = '0;
		sel = 4'hF;
		seed = 32'h00013B41;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		foreach (offs[j]) rchk(offs[j], rstv[j]);
		b = seed[5:3];
		@(posedge clock);
		ext <= 8'h01 << b;
		repeat (2) @(posedge clock);
		ext <= 8'h00;
		repeat (10) @(posedge clock);
		rchk(8'h10, 32'h0);
		ext <= 8'h01 << b;
		repeat (12) @(posedge clock);
		ext <= 8'h00;
		rchk(8'h10, 32'h1 << b);
		bus(1'b1, 8'h10, 32'hFFFF);
		seed = lfsr(seed);
		k = seed[2:0];
		v = seed[23:8];
		fire(8'h01 << k, 1'b0, n);
		chk("disabled call", 32'(n), 32'd12);
		rchk(8'h10, 32'h100 << k);
		rchk(8'h0C, 32'h0);
		bus(1'b1, 8'h14, 32'hFFFF);
		rchk(8'h0C, idb(k));
		bus(1'b1, 8'h10, 32'hFFFF);
		bus(1'b1, 8'h08, {16'h0, v});
		bus(1'b1, 8'h04, 32'h1FF);
		bus(1'b1, 8'h00, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			k = seed[2:0];
			fire(8'h01 << k, i[0], n);
			chk("latency", 32'(n), 32'(4 + i[0]));
			chk("vector", 32'(pcv), 32'(v));
			rexp = ra;
			rchk(8'h18, 32'h0);
			rchk(8'h00, 32'h3);
			if (i != 2)
				bus(1'b1, 8'h10, 32'hFFFF);
			ret();
			if (i == 2)
			begin
				wcan(1'b0, n);
				chk("return spacing", 32'(n), 32'd2);
				rexp = ra;
				bus(1'b1, 8'h10, 32'hFFFF);
				ret();
			end
		end
		seed = lfsr(seed);
		k = seed[2:0];
		bus(1'b1, 8'h04, 32'h1FF & ~idb(k));
		fire(8'h01 << k, 1'b0, n);
		chk("masked call", 32'(n), 32'd12);
		bus(1'b1, 8'h04, 32'h1FF);
		wcan(1'b0, n);
		chk("unmasked call", 32'(n < 12), 32'd1);
		rout = ra;
		@(posedge clock);
		ev <= 8'h01 << (k ^ 3'h1);
		@(posedge clock);
		ev <= 8'h00;
		rchk(8'h0C, idb(k) | idb(k ^ 3'h1));
		bus(1'b1, 8'h00, 32'h1);
		wcan(1'b0, n);
		chk("nested call", 32'(n < 12), 32'd1);
		rexp = ra;
		bus(1'b1, 8'h10, 32'hFFFF);
		ret();
		rexp = rout;
		ret();
		rchk(8'h18, 32'hF);
		rchk(8'h1C, 32'h0);
		conclude();
	end
endmodule
bind svih_top svih_top_assertions chk (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.core_return_from_handler(core_return_from_handler), .core_pfx_wr(core_pfx_wr), .cpu_fetch_cancel(cpu_fetch_cancel),
	.cpu_pc_load(cpu_pc_load), .cpu_pc_value(cpu_pc_value), .irq_in_service(irq_in_service));
`default_nettype wire
